// ===== rtcc_defs.svh
// Register indices, field positions, reset values and sync timing for the counter control block.
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH

`define RTCC_IDX_W          6
`define RTCC_IDX_CONTROL_A  6'h00
`define RTCC_IDX_STATUS     6'h01
`define RTCC_IDX_IRQ_ENABLE 6'h02
`define RTCC_IDX_IRQ_FLAGS  6'h03
`define RTCC_IDX_LATCH      6'h04
`define RTCC_IDX_DEBUG      6'h05
`define RTCC_IDX_COUNT_LO   6'h08
`define RTCC_IDX_COUNT_HI   6'h09

`define RTCC_CTRL_ENABLE    0
`define RTCC_CTRL_FREQ_FIX  2
`define RTCC_CTRL_PRESC_LO  3
`define RTCC_CTRL_PRESC_HI  6
`define RTCC_CTRL_STANDBY   7
`define RTCC_CTRL_WMASK     8'hfd

`define RTCC_IRQ_WRAP       0
`define RTCC_IRQ_MATCH      1
`define RTCC_IRQ_WMASK      8'h03
`define RTCC_DBG_RUN        0

`define RTCC_RST_BYTE       8'h00
`define RTCC_RST_COUNT      16'h0000

`define RTCC_SYNC_TICKS     2

`endif

// ===== rtcc_pkg.sv
// Types shared by the counter control block.
package rtcc_pkg;

    // Transfer of a written value into the counter tick domain, coded 00, 01, 11.
    typedef enum logic [1:0] {
        RTCC_SYNC_IDLE  = 2'b00,
        RTCC_SYNC_FIRST = 2'b01,
        RTCC_SYNC_LAST  = 2'b11
    } rtcc_sync_t;

endpackage : rtcc_pkg

// ===== rtcc_core.sv
// Control, status, flag, latch and debug logic of the 16-bit real-time counter.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.svh"

// Function
// R1: Control bit 7 set keeps counting in standby; clear stops it in standby.
// R2: Control bits 6:3 divide counter ticks by two to the field value.
// R3: A control write reaches the counter logic two counter ticks later.
// R4: Software waits for control busy to read zero before rewriting control.
// R5: Control bit 2 enables frequency correction.
// R6: Control bit 0 enables the counter.
// R7: Status bit 3 shows a match value still transferring.
// R8: Status bit 2 shows a wrap value still transferring.
// R9: Status bit 1 shows a count value still transferring.
// R10: Status bit 0 shows a control value still transferring.
// R11: Enable bit 1 enables the match interrupt source.
// R12: Enable bit 0 enables the wrap interrupt source.
// R13: Flag bit 1 sets when the count equals the match value.
// R14: Flag bit 0 sets when the count reaches the wrap value and restarts.
// R15: Writing one clears a flag; writing zero leaves it.
// R16: One shared byte latch makes 16-bit count accesses atomic.
// R17: Without run-during-break, a debug break halts counting and ignores events.
// R18: With run-during-break, counting continues during a debug break.
// R19: Interrupt request stands while a source is enabled and its flag set.
// R20: Counter logic advances only on its own counter clock ticks.
// R21: The enabled counter advances once per prescaled tick, never while disabled.
module rtcc_core (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        rtc_tick_in,
    input  wire logic        standby_in,
    input  wire logic        debug_halt_in,
    input  wire logic [15:0] match_value_in,
    input  wire logic [15:0] wrap_value_in,
    input  wire logic        match_value_sync_busy_in,
    input  wire logic        wrap_value_sync_busy_in,
    output logic             irq_out,
    output logic             freq_fix_enable_out,
    output logic             counter_running_out,
    output logic      [15:0] count_value_out,
    output logic             match_event_out,
    output logic             wrap_event_out
);

    logic              ack_ff;
    logic [31:0]       dat_ff;
    logic [7:0]        ctrl_shadow_ff;
    logic [7:0]        ctrl_active_ff;
    logic [7:0]        irq_enable_ff;
    logic [7:0]        irq_flags_ff;
    logic [7:0]        latch_ff;
    logic [7:0]        debug_ff;
    logic [15:0]       count_value_ff;
    logic [15:0]       count_shadow_ff;
    logic [14:0]       presc_ff;
    rtcc_pkg::rtcc_sync_t ctrl_state_ff;
    rtcc_pkg::rtcc_sync_t nxt_ctrl_state;
    rtcc_pkg::rtcc_sync_t count_state_ff;
    rtcc_pkg::rtcc_sync_t nxt_count_state;

    // Bus decode: a write takes effect at the edge where the master sees ack.
    wire                    req_w       = wb_cyc_in & wb_stb_in;
    wire [`RTCC_IDX_W-1:0]  idx_w       = wb_adr_in[7:2];
    wire                    wr_fire_w   = req_w & wb_we_in & ack_ff & wb_sel_in[0];
    wire                    rd_take_w   = req_w & ~wb_we_in & ~ack_ff;
    wire [7:0]              wbyte_w     = wb_dat_in[7:0];
    wire                    ctrl_wr_w   = wr_fire_w & (idx_w == `RTCC_IDX_CONTROL_A);
    wire                    irqen_wr_w  = wr_fire_w & (idx_w == `RTCC_IDX_IRQ_ENABLE);
    wire                    flags_wr_w  = wr_fire_w & (idx_w == `RTCC_IDX_IRQ_FLAGS);
    wire                    latch_wr_w  = wr_fire_w & (idx_w == `RTCC_IDX_LATCH);
    wire                    debug_wr_w  = wr_fire_w & (idx_w == `RTCC_IDX_DEBUG);
    wire                    cntlo_wr_w  = wr_fire_w & (idx_w == `RTCC_IDX_COUNT_LO);
    wire                    cnthi_wr_w  = wr_fire_w & (idx_w == `RTCC_IDX_COUNT_HI);
    wire                    cntlo_rd_w  = rd_take_w & (idx_w == `RTCC_IDX_COUNT_LO);

    wire ctrl_busy_w  = (ctrl_state_ff != rtcc_pkg::RTCC_SYNC_IDLE);  // R10
    wire count_busy_w = (count_state_ff != rtcc_pkg::RTCC_SYNC_IDLE); // R9
    wire [7:0] status_w = {4'h0, match_value_sync_busy_in,             // R7
                           wrap_value_sync_busy_in,                    // R8
                           count_busy_w, ctrl_busy_w};
    wire ctrl_apply_w  = (ctrl_state_ff == rtcc_pkg::RTCC_SYNC_LAST) & rtc_tick_in;  // R3
    wire count_apply_w = (count_state_ff == rtcc_pkg::RTCC_SYNC_LAST) & rtc_tick_in;

    // Counting stops when disabled, in standby without keep-alive, or in a held break.
    wire standby_stop_w = standby_in & ~ctrl_active_ff[`RTCC_CTRL_STANDBY];   // R1
    wire debug_stop_w   = debug_halt_in & ~debug_ff[`RTCC_DBG_RUN];           // R17 R18
    wire run_w          = ctrl_active_ff[`RTCC_CTRL_ENABLE]                  // R6
                          & ~standby_stop_w & ~debug_stop_w;
    wire [3:0]  presc_code_w = ctrl_active_ff[`RTCC_CTRL_PRESC_HI:`RTCC_CTRL_PRESC_LO];
    wire [15:0] presc_full_w = (16'h0001 << presc_code_w) - 16'h0001;         // R2
    wire [14:0] presc_mask_w = presc_full_w[14:0];
    wire        presc_hit_w  = ((presc_ff & presc_mask_w) == presc_mask_w);   // R2
    wire        advance_w    = run_w & rtc_tick_in & presc_hit_w;             // R20 R21
    wire        at_wrap_w    = (count_value_ff == wrap_value_in);
    wire        match_set_w  = advance_w & (count_value_ff == match_value_in); // R13
    wire        wrap_set_w   = advance_w & at_wrap_w;                          // R14
    wire [1:0]  flag_set_w   = {match_set_w, wrap_set_w};
    wire [1:0]  flag_clr_w   = flags_wr_w ? wbyte_w[1:0] : 2'h0;               // R15

    logic [7:0] rd_byte_w;
    always_comb begin
        unique case (idx_w)
            `RTCC_IDX_CONTROL_A:  rd_byte_w = ctrl_shadow_ff;
            `RTCC_IDX_STATUS:     rd_byte_w = status_w;
            `RTCC_IDX_IRQ_ENABLE: rd_byte_w = irq_enable_ff;
            `RTCC_IDX_IRQ_FLAGS:  rd_byte_w = irq_flags_ff;
            `RTCC_IDX_LATCH:      rd_byte_w = latch_ff;
            `RTCC_IDX_DEBUG:      rd_byte_w = debug_ff;
            `RTCC_IDX_COUNT_LO:   rd_byte_w = count_value_ff[7:0];
            `RTCC_IDX_COUNT_HI:   rd_byte_w = latch_ff;
            default:              rd_byte_w = 8'h00;
        endcase
    end

    always_comb begin
        nxt_ctrl_state = ctrl_state_ff;
        if (ctrl_wr_w) begin
            nxt_ctrl_state = rtcc_pkg::RTCC_SYNC_FIRST;
        end else if (rtc_tick_in) begin
            unique case (ctrl_state_ff)
                rtcc_pkg::RTCC_SYNC_IDLE:  nxt_ctrl_state = rtcc_pkg::RTCC_SYNC_IDLE;
                rtcc_pkg::RTCC_SYNC_FIRST: nxt_ctrl_state = rtcc_pkg::RTCC_SYNC_LAST;
                rtcc_pkg::RTCC_SYNC_LAST:  nxt_ctrl_state = rtcc_pkg::RTCC_SYNC_IDLE;
                default:                   nxt_ctrl_state = rtcc_pkg::RTCC_SYNC_IDLE;
            endcase
        end
    end

    always_comb begin
        nxt_count_state = count_state_ff;
        if (cnthi_wr_w) begin
            nxt_count_state = rtcc_pkg::RTCC_SYNC_FIRST;
        end else if (rtc_tick_in) begin
            unique case (count_state_ff)
                rtcc_pkg::RTCC_SYNC_IDLE:  nxt_count_state = rtcc_pkg::RTCC_SYNC_IDLE;
                rtcc_pkg::RTCC_SYNC_FIRST: nxt_count_state = rtcc_pkg::RTCC_SYNC_LAST;
                rtcc_pkg::RTCC_SYNC_LAST:  nxt_count_state = rtcc_pkg::RTCC_SYNC_IDLE;
                default:                   nxt_count_state = rtcc_pkg::RTCC_SYNC_IDLE;
            endcase
        end
    end

    // Bus slave: data is registered in the request cycle, ack follows one cycle later.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req_w & ~ack_ff;
            if (rd_take_w) begin
                dat_ff <= {24'h00_0000, rd_byte_w};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_shadow_ff <= `RTCC_RST_BYTE;
            irq_enable_ff  <= `RTCC_RST_BYTE;
            debug_ff       <= `RTCC_RST_BYTE;
        end else begin
            if (ctrl_wr_w) begin
                ctrl_shadow_ff <= wbyte_w & `RTCC_CTRL_WMASK;
            end
            if (irqen_wr_w) begin
                irq_enable_ff <= wbyte_w & `RTCC_IRQ_WMASK;   // R11 R12
            end
            if (debug_wr_w) begin
                debug_ff <= {7'h00, wbyte_w[`RTCC_DBG_RUN]};
            end
        end
    end

    // Counter-side copy of the control byte, updated on the second tick.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_state_ff  <= rtcc_pkg::RTCC_SYNC_IDLE;
            ctrl_active_ff <= `RTCC_RST_BYTE;
        end else begin
            ctrl_state_ff <= nxt_ctrl_state;
            if (ctrl_apply_w && !ctrl_wr_w) begin
                ctrl_active_ff <= ctrl_shadow_ff;   // R3
            end
        end
    end

    // Latch holds the high byte captured on a low read, or the low byte of a write.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            latch_ff        <= `RTCC_RST_BYTE;
            count_shadow_ff <= `RTCC_RST_COUNT;
            count_state_ff  <= rtcc_pkg::RTCC_SYNC_IDLE;
        end else begin
            count_state_ff <= nxt_count_state;
            if (cntlo_rd_w) begin
                latch_ff <= count_value_ff[15:8];   // R16
            end else if (latch_wr_w || cntlo_wr_w) begin
                latch_ff <= wbyte_w;                // R16
            end
            if (cnthi_wr_w) begin
                count_shadow_ff <= {wbyte_w, latch_ff};  // R16
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            presc_ff       <= 15'h0000;
            count_value_ff <= `RTCC_RST_COUNT;
        end else begin
            if (!run_w && !ctrl_active_ff[`RTCC_CTRL_ENABLE]) begin
                presc_ff <= 15'h0000;
            end else if (run_w && rtc_tick_in) begin
                presc_ff <= presc_ff + 15'h0001;   // R2
            end
            if (count_apply_w && !cnthi_wr_w) begin
                count_value_ff <= count_shadow_ff;
            end else if (advance_w) begin
                count_value_ff <= at_wrap_w ? 16'h0000 : count_value_ff + 16'h0001;  // R14 R21
            end
        end
    end

    // A hardware set wins over a simultaneous clear.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_flags_ff <= `RTCC_RST_BYTE;
        end else begin
            irq_flags_ff <= {6'h00, (irq_flags_ff[1:0] & ~flag_clr_w) | flag_set_w};  // R13 R14 R15
        end
    end

    assign wb_ack_out          = ack_ff;
    assign wb_dat_out          = dat_ff;
    assign irq_out             = |(irq_flags_ff[1:0] & irq_enable_ff[1:0]);  // R11 R12 R19
    assign freq_fix_enable_out = ctrl_active_ff[`RTCC_CTRL_FREQ_FIX];        // R5
    assign counter_running_out = run_w;
    assign count_value_out     = count_value_ff;
    assign match_event_out     = match_set_w;
    assign wrap_event_out      = wrap_set_w;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_ctrl_written;
        ctrl_wr_w ##1 status_w[0];
    endsequence

    sequence s_count_written;
        cnthi_wr_w ##1 (status_w[1] && count_state_ff == rtcc_pkg::RTCC_SYNC_FIRST);
    endsequence

    property p_ctrl_busy;
        ctrl_wr_w |-> s_ctrl_written ##0 ctrl_state_ff == rtcc_pkg::RTCC_SYNC_FIRST;
    endproperty
    a_ctrl_busy: assert property (p_ctrl_busy) else $error("control busy not raised"); // R10

    property p_ctrl_apply;
        ctrl_apply_w && !ctrl_wr_w |=> ctrl_active_ff == $past(ctrl_shadow_ff) && !ctrl_busy_w;
    endproperty
    a_ctrl_apply: assert property (p_ctrl_apply) else $error("control not applied"); // R3

    property p_ctrl_hold;
        ctrl_state_ff == rtcc_pkg::RTCC_SYNC_FIRST |=> $stable(ctrl_active_ff);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control applied too early"); // R3

    property p_freq_fix;
        !ctrl_busy_w |-> freq_fix_enable_out == ctrl_shadow_ff[`RTCC_CTRL_FREQ_FIX];
    endproperty
    a_freq_fix: assert property (p_freq_fix) else $error("correction enable mismatch"); // R5

    property p_disabled_still;
        !ctrl_active_ff[`RTCC_CTRL_ENABLE] && !count_busy_w |=> $stable(count_value_ff);
    endproperty
    a_disabled_still: assert property (p_disabled_still) else $error("disabled count moved"); // R6

    property p_standby_still;
        standby_in && !ctrl_active_ff[`RTCC_CTRL_STANDBY] && !count_busy_w
            |=> $stable(count_value_ff);
    endproperty
    a_standby_still: assert property (p_standby_still) else $error("count moved in standby"); // R1

    property p_break_still;
        debug_halt_in && !debug_ff[`RTCC_DBG_RUN] |-> !match_event_out && !wrap_event_out;
    endproperty
    a_break_still: assert property (p_break_still) else $error("event during break"); // R17

    property p_break_run;
        debug_halt_in && debug_ff[`RTCC_DBG_RUN] && ctrl_active_ff[`RTCC_CTRL_ENABLE]
            && !standby_in && presc_code_w == 4'h0 && rtc_tick_in && !count_busy_w
            |=> count_value_ff == ($past(at_wrap_w) ? 16'h0000 : $past(count_value_ff) + 16'h0001);
    endproperty
    a_break_run: assert property (p_break_run) else $error("count halted in break"); // R18

    property p_div2;
        run_w && rtc_tick_in && presc_code_w == 4'h1 && !presc_ff[0] |-> !advance_w;
    endproperty
    a_div2: assert property (p_div2) else $error("prescaler by two advanced early"); // R2

    property p_match_flag;
        match_set_w |=> irq_flags_ff[`RTCC_IRQ_MATCH] ##0 (!irq_enable_ff[1] || irq_out);
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match flag not set"); // R13

    property p_wrap_flag;
        wrap_set_w && !count_apply_w |=> irq_flags_ff[`RTCC_IRQ_WRAP] && count_value_ff == 16'h0000;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag or restart missing"); // R14

    property p_flag_clear;
        flags_wr_w && wbyte_w[0] && !wrap_set_w |=> !irq_flags_ff[`RTCC_IRQ_WRAP];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by one"); // R15

    property p_latch_capture;
        cntlo_rd_w |=> latch_ff == $past(count_value_ff[15:8]);
    endproperty
    a_latch_capture: assert property (p_latch_capture) else $error("high byte not latched"); // R16

    property p_irq_hold;
        irq_out && !flags_wr_w && !irqen_wr_w |=> irq_out;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped early"); // R19

    property p_status_ext;
        status_w[3] == match_value_sync_busy_in && status_w[2] == wrap_value_sync_busy_in;
    endproperty
    a_status_ext: assert property (p_status_ext) else $error("busy bits misplaced"); // R7 R8

    property p_count_busy;
        cnthi_wr_w |-> s_count_written;
    endproperty
    a_count_busy: assert property (p_count_busy) else $error("count busy not raised"); // R9

    property p_irq_match;
        irq_flags_ff[`RTCC_IRQ_MATCH] && irq_enable_ff[`RTCC_IRQ_MATCH] |-> irq_out;
    endproperty
    a_irq_match: assert property (p_irq_match) else $error("match request missing"); // R11 R19

    property p_irq_wrap;
        irq_flags_ff[`RTCC_IRQ_WRAP] && irq_enable_ff[`RTCC_IRQ_WRAP] |-> irq_out;
    endproperty
    a_irq_wrap: assert property (p_irq_wrap) else $error("wrap request missing"); // R12 R19

    property p_match_clear;
        flags_wr_w && wbyte_w[1] && !match_set_w |=> !irq_flags_ff[`RTCC_IRQ_MATCH];
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match flag not cleared"); // R15

    property p_flag_keep;
        flags_wr_w && !wbyte_w[0] && irq_flags_ff[0] |=> irq_flags_ff[0];
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag cleared by zero"); // R15

    property p_count_apply;
        count_apply_w && !cnthi_wr_w
            |=> count_value_ff == $past(count_shadow_ff) && !count_busy_w;
    endproperty
    a_count_apply: assert property (p_count_apply) else $error("count not applied"); // R9

    property p_hi_commit;
        cnthi_wr_w |=> count_shadow_ff == {$past(wbyte_w), $past(latch_ff)};
    endproperty
    a_hi_commit: assert property (p_hi_commit) else $error("wide write not combined"); // R16

    property p_div1;
        run_w && rtc_tick_in && presc_code_w == 4'h0 |-> advance_w;
    endproperty
    a_div1: assert property (p_div1) else $error("undivided tick did not advance"); // R2

endmodule : rtcc_core
`default_nettype wire

// ===== rtcc_core_tb.sv
// Self-checking testbench for the counter control block over its register bus.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.svh"

module rtcc_core_tb;
    logic        clk_in;
    logic        rst_in;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        rtc_tick;
    logic        standby;
    logic        debug_halt;
    logic [15:0] match_value;
    logic [15:0] wrap_value;
    logic        match_busy;
    logic        wrap_busy;
    logic        irq;
    logic        freq_fix;
    logic        running;
    logic [15:0] count_value;
    logic        match_ev;
    logic        wrap_ev;
    int          err_total;
    int          cmp_count;
    int          cyc_n;
    int          match_n;
    int          wrap_n;
    logic [7:0]  rdat;

    rtcc_core dut (
        .clk_in                   (clk_in),
        .rst_in                   (rst_in),
        .wb_cyc_in                (wb_cyc),
        .wb_stb_in                (wb_stb),
        .wb_we_in                 (wb_we),
        .wb_adr_in                (wb_adr),
        .wb_sel_in                (wb_sel),
        .wb_dat_in                (wb_dat_w),
        .wb_dat_out               (wb_dat_r),
        .wb_ack_out               (wb_ack),
        .rtc_tick_in              (rtc_tick),
        .standby_in               (standby),
        .debug_halt_in            (debug_halt),
        .match_value_in           (match_value),
        .wrap_value_in            (wrap_value),
        .match_value_sync_busy_in (match_busy),
        .wrap_value_sync_busy_in  (wrap_busy),
        .irq_out                  (irq),
        .freq_fix_enable_out      (freq_fix),
        .counter_running_out      (running),
        .count_value_out          (count_value),
        .match_event_out          (match_ev),
        .wrap_event_out           (wrap_ev)
    );

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    always @(posedge clk_in) begin
        cyc_n <= cyc_n + 1;
        if (match_ev === 1'b1) begin
            match_n <= match_n + 1;
        end
        if (wrap_ev === 1'b1) begin
            wrap_n <= wrap_n + 1;
        end
        if (cyc_n > 20000) begin
            err_total = err_total + 1;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= {idx, 2'b00};
        wb_sel   <= 4'h1;
        wb_dat_w <= {24'h000000, d};
        do begin
            @(posedge clk_in);
        end while (wb_ack !== 1'b1);
        rdat = wb_dat_r[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk_in);
    endtask : wb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk({8'h00, rdat}, {8'h00, exp});
    endtask : rd

    // Outputs are sampled when look is called and compared at the next falling edge.
    task automatic look(input logic [15:0] got, input logic [15:0] exp);
        @(negedge clk_in);
        chk(got, exp);
        @(posedge clk_in);
    endtask : look

    task automatic ticks(input int n);
        repeat (n) begin
            rtc_tick <= 1'b1;
            @(posedge clk_in);
            rtc_tick <= 1'b0;
            @(posedge clk_in);
        end
        repeat (3) @(posedge clk_in);
    endtask : ticks

    task automatic set_ctrl(input logic [7:0] v);
        wr(`RTCC_IDX_CONTROL_A, v);
        ticks(2);
        rd(`RTCC_IDX_STATUS, 8'h00);
    endtask : set_ctrl

    initial begin
        {wb_cyc, wb_stb, wb_we, rtc_tick, debug_halt, match_busy, wrap_busy} = '0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h00000000;
        standby = 1'b1;
        match_value = 16'h0103;
        wrap_value = 16'h0104;
        err_total = 0;
        cmp_count = 0;
        cyc_n = 0;
        match_n = 0;
        wrap_n = 0;
        rst_in = 1'b1;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        for (int i = 0; i < 7; i++) begin
            rd(i[5:0], 8'h00);
        end
        match_busy <= 1'b1;
        rd(`RTCC_IDX_STATUS, 8'h08);
        match_busy <= 1'b0;
        wrap_busy <= 1'b1;
        rd(`RTCC_IDX_STATUS, 8'h04);
        wrap_busy <= 1'b0;
        $display("Test reset and status done");
        wr(`RTCC_IDX_CONTROL_A, 8'hff);
        rd(`RTCC_IDX_CONTROL_A, 8'hfd);
        rd(`RTCC_IDX_STATUS, 8'h01);
        ticks(1);
        look({15'h0000, freq_fix}, 16'h0000);
        ticks(1);
        rd(`RTCC_IDX_STATUS, 8'h00);
        look({15'h0000, freq_fix}, 16'h0001);
        look({15'h0000, running}, 16'h0001);
        set_ctrl(8'h04);
        look({15'h0000, running}, 16'h0000);
        for (int c = 0; c < 16; c++) begin
            set_ctrl({1'b0, c[3:0], 3'b000});
            rd(`RTCC_IDX_CONTROL_A, {1'b0, c[3:0], 3'b000});
        end
        look({15'h0000, freq_fix}, 16'h0000);
        $display("Test control sync done");
        set_ctrl(8'h01);
        ticks(3);
        look(count_value, 16'h0000);
        standby <= 1'b0;
        ticks(3);
        look(count_value, 16'h0003);
        debug_halt <= 1'b1;
        ticks(2);
        look(count_value, 16'h0003);
        wr(`RTCC_IDX_DEBUG, 8'h01);
        rd(`RTCC_IDX_DEBUG, 8'h01);
        ticks(2);
        look(count_value, 16'h0005);
        debug_halt <= 1'b0;
        standby <= 1'b1;
        set_ctrl(8'h08);
        set_ctrl(8'h09);
        standby <= 1'b0;
        ticks(2);
        look(count_value, 16'h0006);
        ticks(2);
        look(count_value, 16'h0007);
        standby <= 1'b1;
        $display("Test counting done");
        set_ctrl(8'h01);
        wr(`RTCC_IDX_COUNT_LO, 8'h02);
        wr(`RTCC_IDX_COUNT_HI, 8'h01);
        rd(`RTCC_IDX_STATUS, 8'h02);
        ticks(2);
        rd(`RTCC_IDX_STATUS, 8'h00);
        look(count_value, 16'h0102);
        rd(`RTCC_IDX_COUNT_LO, 8'h02);
        rd(`RTCC_IDX_LATCH, 8'h01);
        rd(`RTCC_IDX_COUNT_HI, 8'h01);
        $display("Test wide access done");
        wr(`RTCC_IDX_IRQ_ENABLE, 8'h02);
        rd(`RTCC_IDX_IRQ_ENABLE, 8'h02);
        standby <= 1'b0;
        ticks(3);
        look(count_value, 16'h0000);
        chk(match_n[15:0], 16'h0001);
        chk(wrap_n[15:0], 16'h0001);
        rd(`RTCC_IDX_IRQ_FLAGS, 8'h03);
        look({15'h0000, irq}, 16'h0001);
        wr(`RTCC_IDX_IRQ_FLAGS, 8'h02);
        rd(`RTCC_IDX_IRQ_FLAGS, 8'h01);
        look({15'h0000, irq}, 16'h0000);
        wr(`RTCC_IDX_IRQ_ENABLE, 8'h01);
        look({15'h0000, irq}, 16'h0001);
        wr(`RTCC_IDX_IRQ_FLAGS, 8'h00);
        rd(`RTCC_IDX_IRQ_FLAGS, 8'h01);
        wr(`RTCC_IDX_IRQ_FLAGS, 8'h01);
        look({15'h0000, irq}, 16'h0000);
        $display("Test flags done");
        close_out();
    end
endmodule : rtcc_core_tb

`default_nettype wire
